// *** rtl/clock_select_flags.v ***
// Clock source selection, low-power wait handling, crystal stop, halt
// handling and reset-cause flags of the clock and reset unit.
// Assumes all inputs synchronous to sys_clk_in; registers over classic
// Wishbone; the clock sources themselves are given as enables/levels.
//
// Function
// - Int source bit picks external or unit IRQ
// - Halt resets if enabled, else stops oscillator
// - Aux select takes effect only if present
// - Low-power wait picks div16 or aux clock
// - Aux stays selected after wait without stop
// - Wait without low-power leaves system clock alone
// - Flag register reset value follows reset cause
// - Stop flag set after instruction, software clears
// - Watchdog and soft flags encode reset cause
// - Crystal stops once aux present and selected
// - Crystal stop bit reads zero until aux active
// - Div16 zero picks div16, PLL off; toggles interrupt
// - Aux active only when aux truly selected
// - Lock bit shows PLL lock; unlocked PLL used only with freerun
// - Hardware clears PLL select on listed events
// - PLL select uses PLL once locked or freerun
// - Aux overrides all; div16 zero overrides PLL
// - Clock events raise falling-edge interrupt request
`timescale 1ns/1ps
`include "clock_select_regs.vh"

module clock_select_flags (
   // Clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   input wire [1:0] reset_cause_in,
   // Wishbone slave
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [7:0] wb_adr_in,
   input wire [7:0] wb_dat_in,
   input wire wb_sel_in,
   output wire wb_ack_out,
   output reg [7:0] wb_dat_out,
   // Core events
   input wire wait_for_interrupt_in,
   input wire wait_exit_in,
   input wire halt_in,
   input wire stop_mode_in,
   input wire instr_end_in,
   input wire stop_restart_in,
   // Clock sources and external interrupt
   input wire aux_clock_present_in,
   input wire pll_locked_in,
   input wire pll_freerun_enable_in,
   input wire [2:0] pll_divider_field_in,
   input wire ext_irq_in,
   // Clock and power controls, reset request and shared interrupt
   output reg [1:0] system_clock_sel_out,
   output reg core_clock_stop_out,
   output reg crystal_off_out,
   output reg pll_off_out,
   output reg unit_off_out,
   output reg soft_reset_req_out,
   output reg shared_irq_out
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   reg [7:0] ctrl_r;           // Clock control register
   reg xtal_stop_en_r;         // Crystal stop enable, as written
   reg div16_r;                // Divide-by-16 control
   reg pll_sel_r;              // PLL output select
   reg ext_stop_r;             // External stop flag
   reg stop_pending_r;         // Stop entered, flag set at instr end
   reg [1:0] cause_r;          // Captured reset cause
   reg cause_load_r;           // Cause still to be captured
   reg lowpower_wait_r;        // Low-power wait in progress
   reg ack_r;                  // Bus acknowledge
   reg [1:0] src_r;            // Currently running source
   reg [1:0] src_pend_r;       // Requested source awaiting switch
   reg [1:0] switch_cnt_r;     // Cycles left before a source switch
   reg lock_d_r;               // Lock seen last cycle
   reg [2:0] irq_cnt_r;        // Low pulse length of unit IRQ
   reg [1:0] src_nxt;          // Requested source

   wire bus_req = wb_cyc_in & wb_stb_in;
   wire wr_ctrl = bus_req & wb_we_in & wb_sel_in & ~ack_r &
      (wb_adr_in == `CLOCK_CONTROL_OFFSET);
   wire wr_flag = bus_req & wb_we_in & wb_sel_in & ~ack_r &
      (wb_adr_in == `CLOCK_FLAG_OFFSET);
   wire wait_entry = wait_for_interrupt_in & ctrl_r[`CC_LOWPOWER_BIT];
   wire aux_active = (src_r == `SRC_AUX);
   wire aux_wanted = (ctrl_r[`CC_AUX_SELECT_BIT] |
      (lowpower_wait_r & ctrl_r[`CC_WAIT_CLOCK_BIT])) & aux_clock_present_in;
   wire xtal_stopped = xtal_stop_en_r & aux_active;
   wire [7:0] flag_view = {ext_stop_r, cause_r,
      xtal_stop_en_r & aux_active, div16_r, aux_active,
      pll_locked_in & ~pll_off_out, pll_sel_r};

   // -------------------------------------------------------------------
   // Wishbone: one-cycle ack, unmapped reads zero, writes ignored
   // -------------------------------------------------------------------
   assign wb_ack_out = ack_r;

   // Ack and read data register
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_r <= 1'b0;
         wb_dat_out <= 8'h00;
      end else begin
         ack_r <= bus_req & ~ack_r;
         if (bus_req & ~ack_r & ~wb_we_in) begin
            if (wb_adr_in == `CLOCK_CONTROL_OFFSET)
               wb_dat_out <= ctrl_r;
            else if (wb_adr_in == `CLOCK_FLAG_OFFSET)
               wb_dat_out <= flag_view;
            else
               wb_dat_out <= 8'h00;
         end
      end
   end

   // -------------------------------------------------------------------
   // Clock control register
   // -------------------------------------------------------------------
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_r <= `CLOCK_CONTROL_RESET;
      end else if (wr_ctrl) begin
         // Test bits are kept as written; software holds them at zero
         ctrl_r <= wb_dat_in;
      end else if (wait_exit_in & lowpower_wait_r &
         ctrl_r[`CC_WAIT_CLOCK_BIT] & aux_active & ~xtal_stop_en_r) begin
         // Wait clock on aux latches the select bit so aux stays on
         ctrl_r[`CC_AUX_SELECT_BIT] <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Reset cause capture, one cycle after release
   // -------------------------------------------------------------------
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cause_r <= `CAUSE_EXT;
         cause_load_r <= 1'b1;
      end else if (cause_load_r) begin
         // Watchdog bit is high bit, software bit low
         cause_r <= reset_cause_in;
         cause_load_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Flag register writable bits and hardware events
   // -------------------------------------------------------------------
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ext_stop_r <= 1'b0;
         stop_pending_r <= 1'b0;
         xtal_stop_en_r <= 1'b0;
         div16_r <= 1'b1;
         pll_sel_r <= 1'b0;
         lowpower_wait_r <= 1'b0;
      end else begin
         // Stop flag: set after the current instruction, set beats clear
         if (stop_mode_in)
            stop_pending_r <= 1'b1;
         else if (instr_end_in)
            stop_pending_r <= 1'b0;
         if (stop_pending_r & instr_end_in)
            ext_stop_r <= 1'b1;
         else if (wr_flag)
            ext_stop_r <= wb_dat_in[`CF_EXT_STOP_BIT];
         // Written 1 holds, but reads 0 while aux inactive
         if (wr_flag)
            xtal_stop_en_r <= wb_dat_in[`CF_XTAL_STOP_BIT];
         if (wr_flag)
            div16_r <= wb_dat_in[`CF_DIV16_BIT];
         // PLL select: hardware clear wins over a software set
         if ((pll_divider_field_in == `PLL_DIVIDER_OFF) | xtal_stopped |
            wait_entry | (wr_flag & ~wb_dat_in[`CF_DIV16_BIT]) |
            ~div16_r)
            pll_sel_r <= 1'b0;
         else if (wr_flag)
            pll_sel_r <= wb_dat_in[`CF_PLL_SELECT_BIT];
         // Low-power wait lasts from entry until exit
         if (wait_entry)
            lowpower_wait_r <= 1'b1;
         else if (wait_exit_in)
            lowpower_wait_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Requested source, by priority
   // -------------------------------------------------------------------
   always @* begin
      src_nxt = `SRC_HALF;
      if (aux_wanted)
         src_nxt = `SRC_AUX;
      else if (lowpower_wait_r | ~div16_r)
         src_nxt = `SRC_DIV16;
      else if (pll_sel_r & (pll_locked_in | pll_freerun_enable_in))
         src_nxt = `SRC_PLL;
      else
         src_nxt = `SRC_HALF;
   end

   // -------------------------------------------------------------------
   // Delayed switch: old source held for two cycles, then new source
   // -------------------------------------------------------------------
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         src_r <= `SRC_HALF;
         src_pend_r <= `SRC_HALF;
         switch_cnt_r <= 2'h0;
         system_clock_sel_out <= `SRC_HALF;
      end else begin
         if (switch_cnt_r != 2'h0) begin
            switch_cnt_r <= switch_cnt_r - 2'h1;
            if (switch_cnt_r == 2'h1) begin
               src_r <= src_pend_r;
               system_clock_sel_out <= src_pend_r;
            end
         end else if (src_nxt != src_r) begin
            // Aux held after wait without crystal stop, until software clears the select bit
            src_pend_r <= src_nxt;
            switch_cnt_r <= 2'h2;
         end
      end
   end

   // -------------------------------------------------------------------
   // Power controls, halt handling and core clock
   // -------------------------------------------------------------------
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         crystal_off_out <= 1'b0;
         pll_off_out <= 1'b1;
         unit_off_out <= 1'b0;
         soft_reset_req_out <= 1'b0;
         core_clock_stop_out <= 1'b0;
      end else begin
         soft_reset_req_out <= halt_in & ctrl_r[`CC_HALT_RESET_BIT];
         if (halt_in & ~ctrl_r[`CC_HALT_RESET_BIT]) begin
            unit_off_out <= 1'b1;
         end
         crystal_off_out <= xtal_stopped |
            unit_off_out;
         pll_off_out <= unit_off_out | ~div16_r |
            (pll_divider_field_in == `PLL_DIVIDER_OFF) |
            (lowpower_wait_r & ~pll_freerun_enable_in);
         if (wait_for_interrupt_in)
            core_clock_stop_out <= 1'b1;
         else if (wait_exit_in)
            core_clock_stop_out <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Clock unit interrupt: low pulse on events; shared request mux
   // -------------------------------------------------------------------
   wire aux_edge = (switch_cnt_r == 2'h1) &
      ((src_pend_r == `SRC_AUX) != aux_active);
   wire div_edge = (switch_cnt_r == 2'h1) &
      ((src_pend_r == `SRC_DIV16) != (src_r == `SRC_DIV16));
   // Low pulse length, cut to the counter width on purpose
   wire [31:0] irq_low_full = `IRQ_LOW_CYCLES;
   wire clk_event = aux_edge | div_edge | stop_restart_in |
      (lock_d_r != pll_locked_in) |
      (wr_flag & (wb_dat_in[`CF_DIV16_BIT] != div16_r));

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lock_d_r <= 1'b0;
         irq_cnt_r <= 3'h0;
         shared_irq_out <= 1'b1;
      end else begin
         lock_d_r <= pll_locked_in;
         if (clk_event)
            irq_cnt_r <= irq_low_full[2:0];
         else if (irq_cnt_r != 3'h0)
            irq_cnt_r <= irq_cnt_r - 3'h1;
         if (ctrl_r[`CC_INT_SOURCE_BIT])
            shared_irq_out <= ~(clk_event | (irq_cnt_r > 3'h1));
         else
            shared_irq_out <= ext_irq_in;
      end
   end

endmodule

// *** pkg/clock_select_regs.vh ***
// Register offsets, bit positions, reset values and timing counts of the
// clock select and reset flag block.
// Assumes inclusion by bare name from a design file in rtl/.
`ifndef CLOCK_SELECT_REGS_VH
`define CLOCK_SELECT_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CLOCK_CONTROL_OFFSET 8'hF0
`define CLOCK_FLAG_OFFSET 8'hF2

// ----------------------------------------------------------------------
// Clock control register fields
// ----------------------------------------------------------------------
`define CC_INT_SOURCE_BIT 7
`define CC_HALT_RESET_BIT 3
`define CC_AUX_SELECT_BIT 2
`define CC_WAIT_CLOCK_BIT 1
`define CC_LOWPOWER_BIT 0
`define CC_WRITE_MASK 8'h8F
`define CLOCK_CONTROL_RESET 8'h00

// ----------------------------------------------------------------------
// Clock flag register fields
// ----------------------------------------------------------------------
`define CF_EXT_STOP_BIT 7
`define CF_WATCHDOG_BIT 6
`define CF_SOFT_BIT 5
`define CF_XTAL_STOP_BIT 4
`define CF_DIV16_BIT 3
`define CF_AUX_ACTIVE_BIT 2
`define CF_LOCK_BIT 1
`define CF_PLL_SELECT_BIT 0
`define CLOCK_FLAG_RESET_LVD 8'h68
`define CLOCK_FLAG_RESET_WDG 8'h48
`define CLOCK_FLAG_RESET_SOFT 8'h28
`define CLOCK_FLAG_RESET_EXT 8'h08

// ----------------------------------------------------------------------
// Reset cause codes and source codes
// ----------------------------------------------------------------------
`define CAUSE_EXT 2'h0
`define CAUSE_SOFT 2'h1
`define CAUSE_WDG 2'h2
`define CAUSE_LVD 2'h3
`define SRC_HALF 2'h0
`define SRC_DIV16 2'h1
`define SRC_PLL 2'h2
`define SRC_AUX 2'h3
`define PLL_DIVIDER_OFF 3'h7

// ----------------------------------------------------------------------
// Timing: clock unit interrupt low pulse, in ns, and cycles at 40 MHz
// ----------------------------------------------------------------------
`define SYS_CLK_PERIOD_NS 25
`define IRQ_LOW_TIME_NS 100
`define IRQ_LOW_CYCLES ((`IRQ_LOW_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// *** test/clock_select_monitor.sv ***
// Checker for the clock select block, watching its ports only.
// Assumes a bind onto clock_select_flags; shadows the control register.
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module clock_select_monitor (
   // Clock, reset and bus
   input wire sys_clk_in,
   input wire rst_in,
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire wb_sel_in,
   input wire [7:0] wb_adr_in,
   input wire [7:0] wb_dat_in,
   input wire wb_ack_out,
   // Events and outputs
   input wire wait_for_interrupt_in,
   input wire halt_in,
   input wire pll_freerun_enable_in,
   input wire [2:0] pll_divider_field_in,
   input wire [1:0] system_clock_sel_out,
   input wire core_clock_stop_out,
   input wire crystal_off_out,
   input wire pll_off_out,
   input wire unit_off_out,
   input wire soft_reset_req_out,
   input wire shared_irq_out
);
   // ----------------------------------------------------------------
   // Shadow of the control register
   // ----------------------------------------------------------------
   wire bus_take = wb_cyc_in && wb_stb_in && !wb_ack_out; // Request taken
   reg [7:0] ctl_r; // Copy of the last control write
   // Follow writes at the edge where the slave takes them
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in)
         ctl_r <= 8'h00;
      else if (bus_take && wb_we_in && wb_sel_in &&
               wb_adr_in == `CLOCK_CONTROL_OFFSET)
         ctl_r <= wb_dat_in;
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_irq_low;
      (!shared_irq_out)[*4];
   endsequence
   sequence s_halt_off;
      ##[1:2] (crystal_off_out && pll_off_out && unit_off_out);
   endsequence
   property p_ack_pulse;
      wb_ack_out |=> !wb_ack_out;
   endproperty
   property p_ack_answer;
      bus_take |=> wb_ack_out;
   endproperty
   property p_halt_reset;
      halt_in && ctl_r[3] |-> ##[1:2] soft_reset_req_out;
   endproperty
   property p_halt_off;
      halt_in && !ctl_r[3] |-> s_halt_off;
   endproperty
   property p_wait_plain;
      wait_for_interrupt_in && !ctl_r[0] |-> ##[1:2] core_clock_stop_out;
   endproperty
   property p_wait_div16;
      wait_for_interrupt_in && ctl_r[0] && !ctl_r[1] && !ctl_r[2]
         |-> ##[1:4] system_clock_sel_out == `SRC_DIV16;
   endproperty
   property p_divider_off;
      pll_divider_field_in == `PLL_DIVIDER_OFF && !pll_freerun_enable_in
         |-> ##[1:6] system_clock_sel_out != `SRC_PLL;
   endproperty
   property p_irq_pulse;
      ctl_r[7] && $fell(shared_irq_out) |-> s_irq_low;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (p_ack_answer)
      else $error("no ack one cycle after request");
   a_halt_reset: assert property (p_halt_reset)
      else $error("halt gave no reset request");
   a_halt_off: assert property (p_halt_off)
      else $error("halt did not stop oscillator, pll and unit");
   a_wait_plain: assert property (p_wait_plain)
      else $error("wait did not stop core clock");
   a_wait_div16: assert property (p_wait_div16)
      else $error("low power wait did not pick div16 clock");
   a_divider_off: assert property (p_divider_off)
      else $error("pll kept with divider off");
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("unit interrupt low pulse too short");
endmodule
bind clock_select_flags clock_select_monitor u_mon (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_sel_in(wb_sel_in),
   .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
   .wait_for_interrupt_in(wait_for_interrupt_in), .halt_in(halt_in),
   .pll_freerun_enable_in(pll_freerun_enable_in),
   .pll_divider_field_in(pll_divider_field_in),
   .system_clock_sel_out(system_clock_sel_out),
   .core_clock_stop_out(core_clock_stop_out),
   .crystal_off_out(crystal_off_out), .pll_off_out(pll_off_out),
   .unit_off_out(unit_off_out), .soft_reset_req_out(soft_reset_req_out),
   .shared_irq_out(shared_irq_out));

// *** test/clock_select_flags_test.sv ***
// Self-checking bench for the clock select block over classic Wishbone.
// Assumes the register header is on the include path.
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module clock_select_flags_test;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam [7:0] ctl = `CLOCK_CONTROL_OFFSET; // Control offset
   localparam [7:0] flg = `CLOCK_FLAG_OFFSET; // Flag offset
   reg clk, rst, cyc, stb, we, sel, aux, lock, frun, ext;
   reg [1:0] cause;
   reg [2:0] div;
   reg [5:0] ev; // Core event pulses
   reg [7:0] adr, dat, v;
   wire ack, cstop, xoff, poff, uoff, srst, irq;
   wire [7:0] rdat;
   wire [1:0] src;
   integer failures, comparisons, i, n;
   always #12.5 clk = ~clk;
   clock_select_flags uut (.sys_clk_in(clk), .rst_in(rst),
      .reset_cause_in(cause), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel),
      .wb_ack_out(ack), .wb_dat_out(rdat), .wait_for_interrupt_in(ev[0]),
      .wait_exit_in(ev[1]), .halt_in(ev[2]), .stop_mode_in(ev[3]),
      .instr_end_in(ev[4]), .stop_restart_in(ev[5]),
      .aux_clock_present_in(aux), .pll_locked_in(lock),
      .pll_freerun_enable_in(frun), .pll_divider_field_in(div),
      .ext_irq_in(ext), .system_clock_sel_out(src),
      .core_clock_stop_out(cstop), .crystal_off_out(xoff),
      .pll_off_out(poff), .unit_off_out(uoff),
      .soft_reset_req_out(srst), .shared_irq_out(irq));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task results;
      begin
         $display("comparisons %0d failures %0d", comparisons, failures);
         if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task tick(input integer k);
      repeat (k) @(posedge clk);
   endtask
   // One classic cycle; held until ack is sampled high
   task bus(input w, input [7:0] a, input [7:0] d);
      integer k;
      begin
         @(posedge clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         dat <= d;
         k = 0;
         @(posedge clk);
         while (ack !== 1'b1 && k < 20) begin
            k = k + 1;
            @(posedge clk);
         end
         v = rdat;
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
         if (k == 20) begin
            failures = failures + 1;
            results;
         end
      end
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      begin
         bus(1'b0, a, 8'h00);
         chk($sformatf("register %h", a), v, e);
      end
   endtask
   task cks(input [1:0] e);
      chk("clock select", {6'h00, src}, {6'h00, e});
   endtask
   task pulse(input integer k);
      begin
         @(posedge clk);
         ev[k] <= 1'b1;
         @(posedge clk);
         ev[k] <= 1'b0;
      end
   endtask
   task do_reset(input [1:0] c);
      begin
         @(posedge clk);
         rst <= 1'b1;
         cause <= c;
         tick(6);
         rst <= 1'b0;
         tick(3);
      end
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; sel = 1; aux = 0;
      lock = 0; frun = 0; ext = 1; cause = 0; div = 0; ev = 0;
      adr = 0; dat = 0; failures = 0; comparisons = 0;
      for (i = 3; i >= 0; i = i - 1) begin
         do_reset(i[1:0]);
         rdc(flg, {1'b0, i[1:0], 5'h08});
      end
      rdc(ctl, 8'h00);
      rdc(8'h10, 8'h00);
      bus(1'b1, flg, 8'h68);
      rdc(flg, 8'h08);
      $display("reset test done");
      bus(1'b1, ctl, 8'h04);
      tick(3);
      cks(`SRC_HALF);
      bus(1'b1, flg, 8'h18);
      rdc(flg, 8'h08);
      aux <= 1'b1;
      tick(4);
      cks(`SRC_AUX);
      rdc(flg, 8'h1C);
      chk("crystal off", {7'h00, xoff}, 8'h01);
      bus(1'b1, flg, 8'h08);
      tick(20);
      bus(1'b1, ctl, 8'h00);
      tick(3);
      cks(`SRC_HALF);
      $display("aux test done");
      lock <= 1'b1;
      bus(1'b1, flg, 8'h09);
      tick(3);
      cks(`SRC_PLL);
      rdc(flg, 8'h0B);
      div <= 3'h7;
      lock <= 1'b0;
      tick(4);
      cks(`SRC_HALF);
      rdc(flg, 8'h08);
      div <= 3'h0;
      frun <= 1'b1;
      bus(1'b1, flg, 8'h09);
      tick(3);
      cks(`SRC_PLL);
      frun <= 1'b0;
      tick(4);
      cks(`SRC_HALF);
      bus(1'b1, ctl, 8'h80);
      tick(6);
      bus(1'b1, flg, 8'h01);
      n = 0;
      while (irq !== 1'b0 && n < 8) begin
         @(posedge clk);
         n = n + 1;
      end
      chk("irq low", {7'h00, irq}, 8'h00);
      tick(3);
      cks(`SRC_DIV16);
      rdc(flg, 8'h00);
      bus(1'b1, ctl, 8'h00);
      ext <= 1'b0;
      tick(3);
      chk("shared irq", {7'h00, irq}, 8'h00);
      ext <= 1'b1;
      tick(3);
      chk("shared irq", {7'h00, irq}, 8'h01);
      bus(1'b1, flg, 8'h08);
      $display("pll test done");
      tick(8);
      pulse(0);
      tick(2);
      cks(`SRC_HALF);
      chk("core stop", {7'h00, cstop}, 8'h01);
      pulse(1);
      bus(1'b1, ctl, 8'h01);
      pulse(0);
      tick(4);
      cks(`SRC_DIV16);
      pulse(1);
      bus(1'b1, ctl, 8'h03);
      pulse(0);
      tick(4);
      cks(`SRC_AUX);
      pulse(1);
      tick(3);
      cks(`SRC_AUX);
      bus(1'b1, ctl, 8'h00);
      tick(3);
      bus(1'b0, flg, 8'h00);
      chk("aux active", {7'h00, v[2]}, 8'h00);
      $display("wait test done");
      pulse(3);
      bus(1'b0, flg, 8'h00);
      chk("stop flag", {7'h00, v[7]}, 8'h00);
      pulse(4);
      bus(1'b0, flg, 8'h00);
      chk("stop flag", {7'h00, v[7]}, 8'h01);
      bus(1'b1, flg, 8'h08);
      bus(1'b0, flg, 8'h00);
      chk("stop flag", {7'h00, v[7]}, 8'h00);
      bus(1'b1, ctl, 8'h08);
      pulse(2);
      tick(1);
      chk("reset request", {7'h00, srst}, 8'h01);
      tick(2);
      bus(1'b1, ctl, 8'h00);
      pulse(2);
      tick(3);
      chk("unit off", {5'h00, xoff, poff, uoff}, 8'h07);
      $display("halt test done");
      results;
   end
endmodule
